// File: rtl/efs_pkg.sv
// Package: constants for the excitation field supervision block
package efs_pkg;
  // ********************
  // Clock and value scaling
  // ********************
  localparam int CLK_HZ = 10_000_000;
  // Setting values carry two decimals: 1.00 is coded as 100
  localparam int VAL_W = 16;
  // Time settings are counts of 5 ms ticks
  localparam int TICK_MS = 5;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int TMR_W = 20;
  // ********************
  // Reset defaults
  // ********************
  localparam logic [VAL_W-1:0] SHORT_LOW_DEF = 16'h0064;   // 1.00
  localparam logic [VAL_W-1:0] OPEN_CTL_HI_DEF = 16'h0064; // 1.00
  localparam logic [VAL_W-1:0] OPEN_CUR_LO_DEF = 16'h000A; // 0.10
  localparam logic [VAL_W-1:0] TEMP_ALARM_DEF = 16'h0064;  // 100
  localparam logic [TMR_W-1:0] OVC_DELAY_DEF = 20'h00258;  // 3.000 s
  localparam logic [TMR_W-1:0] OPEN_DELAY_DEF = 20'h00258; // 3.000 s
  localparam logic [TMR_W-1:0] INV_STOP_DEF = 20'h000C8;   // 1.0 s
  localparam logic [TMR_W-1:0] BRK_SUP_DEF = 20'h00064;    // 0.5 s
  // Ramp rate in 0.01 p.u./s; 0.02 default
  localparam logic [VAL_W-1:0] RAMP_RATE_DEF = 16'h0002;
  // One LSB of control signal is 0.01, rate LSB 0.01/s
  localparam int RAMP_CYC = CLK_HZ;
  localparam int RAMP_W = 24;
  // ********************
  // Breaker trip sequence
  // ********************
  typedef enum logic [3:0] {
    EFS_IDLE = 4'h1,
    EFS_RUNDOWN = 4'h2,
    EFS_SUPERV = 4'h4,
    EFS_DONE = 4'h8
  } efs_brk_t;
endpackage

// File: rtl/efs_supervision.sv
// Module: field overcurrent, open field, temperature and breaker supervision
`timescale 1ns/1ns
module efs_supervision
  import efs_pkg::*;
#(
  parameter int TICK = TICK_CYC,
  parameter int RAMP_DIV = RAMP_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic OVC_ENABLE,
  input wire logic OPEN_MON_ENABLE,
  input wire logic INT_TRIP_ENABLE,
  input wire logic [VAL_W-1:0] SHORT_LOW_LEVEL,
  input wire logic [VAL_W-1:0] OPEN_CTL_HIGH,
  input wire logic [VAL_W-1:0] OPEN_CUR_LOW,
  input wire logic [VAL_W-1:0] TEMP_ALARM_LEVEL,
  input wire logic [TMR_W-1:0] OVC_DELAY,
  input wire logic [TMR_W-1:0] OPEN_DELAY,
  input wire logic [TMR_W-1:0] INV_STOP_TIME,
  input wire logic [TMR_W-1:0] BRK_SUP_TIME,
  input wire logic [VAL_W-1:0] OPEN_LOOP_RATE,
  input wire logic [VAL_W-1:0] CONTROL_SIGNAL,
  input wire logic [VAL_W-1:0] FIELD_CURRENT,
  input wire logic [VAL_W-1:0] IGBT_TEMP,
  input wire logic FIELD_LIMITER_ACTIVE,
  input wire logic MACHINE_CIRCUIT_OPEN,
  input wire logic BREAKER_OFF_REQ,
  input wire logic BREAKER_IS_OPEN,
  input wire logic OPEN_LOOP_REFERENCE_OPTION,
  input wire logic RAMP_UP,
  input wire logic RAMP_DOWN,
  output logic OVC_TRIP,
  output logic OPEN_FIELD_TRIP,
  output logic EXCITATION_STOP,
  output logic TEMP_ALARM,
  output logic TEMP_ALARM_EVENT,
  output logic RUNDOWN_CMD,
  output logic BREAKER_OPEN_CMD,
  output logic BREAKER_FAIL_EVENT,
  output logic [VAL_W-1:0] FORCED_CONTROL_SIGNAL
);
  // Accumulator must hold the divider plus the largest rate step
  if (TICK < 1 || RAMP_DIV < 1
      || RAMP_DIV > (1 << RAMP_W) - (1 << VAL_W)) begin : g_bad_param
    $error("efs_supervision: TICK or RAMP_DIV out of range");
  end

  // Saturating tick counter step, used by every delay timer
  function automatic logic [TMR_W-1:0] tmr_step(input logic [TMR_W-1:0] c,
                                                 input logic run,
                                                 input logic tick);
    if (!run) begin
      return '0;
    end else if (tick && c != '1) begin
      return c + TMR_W'(1);
    end else begin
      return c;
    end
  endfunction

  // ********************
  // Common 5 ms tick
  // ********************
  logic [31:0] pre_q;
  logic tick_q;
  always_ff @(posedge CLK) begin
    if (RST || pre_q == 32'(TICK - 1)) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 32'h1;
    end
  end
  always_ff @(posedge CLK) begin
    tick_q <= !RST && pre_q == 32'(TICK - 1);
  end

  // ********************
  // Field overcurrent
  // ********************
  logic ovc_cond;
  logic [TMR_W-1:0] ovc_cnt_q;
  // Disabled protection holds timer at zero; default off comes from port
  assign ovc_cond = OVC_ENABLE && FIELD_LIMITER_ACTIVE
                    && CONTROL_SIGNAL < SHORT_LOW_LEVEL;
  always_ff @(posedge CLK) begin
    if (RST) begin
      ovc_cnt_q <= '0;
      OVC_TRIP <= 1'b0;
    end else begin
      ovc_cnt_q <= tmr_step(ovc_cnt_q, ovc_cond, tick_q);
      OVC_TRIP <= ovc_cond && ovc_cnt_q >= OVC_DELAY;
    end
  end

  // ********************
  // Open field
  // ********************
  logic open_cond;
  logic [TMR_W-1:0] open_cnt_q;
  assign open_cond = OPEN_MON_ENABLE
                     && CONTROL_SIGNAL > OPEN_CTL_HIGH
                     && FIELD_CURRENT < OPEN_CUR_LOW;
  always_ff @(posedge CLK) begin
    if (RST) begin
      open_cnt_q <= '0;
      OPEN_FIELD_TRIP <= 1'b0;
      EXCITATION_STOP <= 1'b0;
    end else begin
      open_cnt_q <= tmr_step(open_cnt_q, open_cond, tick_q);
      OPEN_FIELD_TRIP <= open_cond && open_cnt_q >= OPEN_DELAY;
      // Stop latches: excitation stays down until reset
      if (open_cond && open_cnt_q >= OPEN_DELAY) begin
        EXCITATION_STOP <= 1'b1;
      end
    end
  end

  // ********************
  // Transistor temperature
  // ********************
  always_ff @(posedge CLK) begin
    if (RST) begin
      TEMP_ALARM <= 1'b0;
      TEMP_ALARM_EVENT <= 1'b0;
    end else begin
      TEMP_ALARM <= IGBT_TEMP > TEMP_ALARM_LEVEL;
      TEMP_ALARM_EVENT <= IGBT_TEMP > TEMP_ALARM_LEVEL
                          && !TEMP_ALARM;
    end
  end

  // ********************
  // Internal field breaker trip
  // ********************
  efs_brk_t brk_q;
  logic [TMR_W-1:0] brk_cnt_q;
  logic brk_start;
  assign brk_start = INT_TRIP_ENABLE && MACHINE_CIRCUIT_OPEN
                     && BREAKER_OFF_REQ;
  always_ff @(posedge CLK) begin
    if (RST) begin
      brk_q <= EFS_IDLE;
      brk_cnt_q <= '0;
      RUNDOWN_CMD <= 1'b0;
      BREAKER_OPEN_CMD <= 1'b0;
      BREAKER_FAIL_EVENT <= 1'b0;
    end else begin
      BREAKER_FAIL_EVENT <= 1'b0;
      case (brk_q)
        EFS_IDLE: begin
          brk_cnt_q <= '0;
          if (brk_start) begin
            brk_q <= EFS_RUNDOWN;
            RUNDOWN_CMD <= 1'b1;
          end
        end
        EFS_RUNDOWN: begin
          brk_cnt_q <= tmr_step(brk_cnt_q, 1'b1, tick_q);
          if (brk_cnt_q >= INV_STOP_TIME) begin
            brk_q <= EFS_SUPERV;
            brk_cnt_q <= '0;
            BREAKER_OPEN_CMD <= 1'b1;
          end
        end
        EFS_SUPERV: begin
          brk_cnt_q <= tmr_step(brk_cnt_q, 1'b1, tick_q);
          if (BREAKER_IS_OPEN) begin
            brk_q <= EFS_DONE;
          end else if (brk_cnt_q >= BRK_SUP_TIME) begin
            brk_q <= EFS_DONE;
            BREAKER_FAIL_EVENT <= 1'b1;
          end
        end
        EFS_DONE: begin
          // Sequence ends once the request is withdrawn
          if (!BREAKER_OFF_REQ) begin
            brk_q <= EFS_IDLE;
            RUNDOWN_CMD <= 1'b0;
            BREAKER_OPEN_CMD <= 1'b0;
          end
        end
        default: begin
          brk_q <= EFS_IDLE;
        end
      endcase
    end
  end

  // ********************
  // Open-loop test ramp
  // ********************
  logic [RAMP_W-1:0] acc_q;
  logic [RAMP_W-1:0] acc_sum;
  logic ramp_run;
  assign ramp_run = OPEN_LOOP_REFERENCE_OPTION && (RAMP_UP ^ RAMP_DOWN);
  assign acc_sum = acc_q + RAMP_W'(OPEN_LOOP_RATE);
  // Fractional accumulator: one LSB step per RAMP_DIV/rate cycles
  always_ff @(posedge CLK) begin
    if (RST || !ramp_run) begin
      acc_q <= '0;
    end else if (acc_sum >= RAMP_W'(RAMP_DIV)) begin
      acc_q <= acc_sum - RAMP_W'(RAMP_DIV);
    end else begin
      acc_q <= acc_sum;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      FORCED_CONTROL_SIGNAL <= '0;
    end else if (!OPEN_LOOP_REFERENCE_OPTION) begin
      // Track live value so the test starts bumpless
      FORCED_CONTROL_SIGNAL <= CONTROL_SIGNAL;
    end else if (ramp_run && acc_sum >= RAMP_W'(RAMP_DIV)) begin
      if (RAMP_UP && FORCED_CONTROL_SIGNAL != '1) begin
        FORCED_CONTROL_SIGNAL <= FORCED_CONTROL_SIGNAL + VAL_W'(1);
      end else if (RAMP_DOWN && FORCED_CONTROL_SIGNAL != '0) begin
        FORCED_CONTROL_SIGNAL <= FORCED_CONTROL_SIGNAL - VAL_W'(1);
      end
    end
  end

  // ********************
  // Checks
  // ********************
  a_ovc_needs_cond: assert property (@(posedge CLK) disable iff (RST)
    OVC_TRIP |-> $past(OVC_ENABLE) && $past(FIELD_LIMITER_ACTIVE)
      && $past(CONTROL_SIGNAL) < $past(SHORT_LOW_LEVEL))
    else $error("overcurrent trip without its condition");
  a_ovc_off_quiet: assert property (@(posedge CLK) disable iff (RST)
    !OVC_ENABLE |=> !OVC_TRIP)
    else $error("overcurrent trip while disabled");
  a_ovc_delay: assert property (@(posedge CLK) disable iff (RST)
    $rose(OVC_TRIP) |-> $past(ovc_cnt_q) >= $past(OVC_DELAY))
    else $error("overcurrent trip before delay");
  a_ovc_restart: assert property (@(posedge CLK) disable iff (RST)
    !ovc_cond |=> ovc_cnt_q == '0)
    else $error("overcurrent timer not restarted");
  a_open_trip_cond: assert property (@(posedge CLK) disable iff (RST)
    OPEN_FIELD_TRIP |-> $past(open_cond)
      && $past(open_cnt_q) >= $past(OPEN_DELAY))
    else $error("open field trip without condition");
  a_open_stops: assert property (@(posedge CLK) disable iff (RST)
    OPEN_FIELD_TRIP |-> EXCITATION_STOP)
    else $error("open field trip without stop");
  a_open_off_quiet: assert property (@(posedge CLK) disable iff (RST)
    !OPEN_MON_ENABLE |=> !OPEN_FIELD_TRIP)
    else $error("open field trip while disabled");
  a_temp_alarm: assert property (@(posedge CLK) disable iff (RST)
    IGBT_TEMP > TEMP_ALARM_LEVEL |=> TEMP_ALARM)
    else $error("temperature alarm missed");
  a_temp_event: assert property (@(posedge CLK) disable iff (RST)
    TEMP_ALARM_EVENT |-> TEMP_ALARM && !$past(TEMP_ALARM))
    else $error("temperature event not on rise");
  a_brk_start: assert property (@(posedge CLK) disable iff (RST)
    brk_q == EFS_IDLE && brk_start |=> RUNDOWN_CMD
      && !BREAKER_OPEN_CMD)
    else $error("rundown not started");
  a_brk_disabled: assert property (@(posedge CLK) disable iff (RST)
    brk_q == EFS_IDLE && !INT_TRIP_ENABLE |=> brk_q == EFS_IDLE)
    else $error("breaker sequence started while disabled");
  a_brk_fail: assert property (@(posedge CLK) disable iff (RST)
    BREAKER_FAIL_EVENT |-> $past(brk_q) == EFS_SUPERV
      && !$past(BREAKER_IS_OPEN))
    else $error("breaker event with breaker open");
  a_ramp_step: assert property (@(posedge CLK) disable iff (RST)
    $past(OPEN_LOOP_REFERENCE_OPTION) && !$past(RAMP_UP)
      |-> FORCED_CONTROL_SIGNAL
      <= $past(FORCED_CONTROL_SIGNAL))
    else $error("ramp rose without up request");
endmodule // efs_supervision

// File: tb/efs_breaker_model.sv
// Partner model: field breaker that opens on command, or sticks closed
`timescale 1ns/1ns
module efs_breaker_model (
  input wire logic CLK,
  input wire logic RST,
  input wire logic open_cmd,
  input wire logic stuck,
  output logic is_open
);
  logic [1:0] travel_q;
  // Contacts need three cycles; stuck contacts never report open
  always_ff @(posedge CLK) begin
    if (RST || !open_cmd) begin
      travel_q <= 2'h0;
    end else if (!stuck && travel_q != 2'h3) begin
      travel_q <= travel_q + 2'h1;
    end
  end
  assign is_open = (travel_q == 2'h3);
endmodule // efs_breaker_model

// File: tb/test_efs_supervision.sv
// Testbench: directed scenarios for the field supervision block
`timescale 1ns/1ns
module test_efs_supervision;
  import efs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ovc_en = 1'b0, open_en = 1'b0, trip_en = 1'b0, lim = 1'b0;
  logic mco = 1'b0, off_req = 1'b0, olr = 1'b0, up = 1'b0, dn = 1'b0;
  logic stuck = 1'b0, brk_open;
  logic [VAL_W-1:0] lvl = SHORT_LOW_DEF, rate = 16'h000A, forced;
  logic [VAL_W-1:0] ctl = 16'h0064, cur = 16'h0032, temp = 16'h0032;
  logic [TMR_W-1:0] dly = 20'h00003, inv = 20'h00003, sup = 20'h00008;
  wire logic [7:0] o;
  int error_cnt = 0, comparisons = 0, cycles = 0, c;
  always #50 clk = ~clk;
  efs_supervision #(.TICK(2), .RAMP_DIV(100)) i_dut (
    .CLK(clk), .RST(rst), .OVC_ENABLE(ovc_en), .OPEN_MON_ENABLE(open_en),
    .INT_TRIP_ENABLE(trip_en), .SHORT_LOW_LEVEL(lvl), .OPEN_CTL_HIGH(lvl),
    .OPEN_CUR_LOW(OPEN_CUR_LO_DEF), .TEMP_ALARM_LEVEL(TEMP_ALARM_DEF),
    .OVC_DELAY(dly), .OPEN_DELAY(dly), .INV_STOP_TIME(inv),
    .BRK_SUP_TIME(sup), .OPEN_LOOP_RATE(rate), .CONTROL_SIGNAL(ctl),
    .FIELD_CURRENT(cur), .IGBT_TEMP(temp), .FIELD_LIMITER_ACTIVE(lim),
    .MACHINE_CIRCUIT_OPEN(mco), .BREAKER_OFF_REQ(off_req),
    .BREAKER_IS_OPEN(brk_open), .OPEN_LOOP_REFERENCE_OPTION(olr),
    .RAMP_UP(up), .RAMP_DOWN(dn), .OVC_TRIP(o[0]), .OPEN_FIELD_TRIP(o[1]),
    .EXCITATION_STOP(o[2]), .TEMP_ALARM(o[3]), .TEMP_ALARM_EVENT(o[4]),
    .RUNDOWN_CMD(o[5]), .BREAKER_OPEN_CMD(o[6]),
    .BREAKER_FAIL_EVENT(o[7]), .FORCED_CONTROL_SIGNAL(forced));
  efs_breaker_model i_brk (.CLK(clk), .RST(rst), .open_cmd(o[6]),
    .stuck(stuck), .is_open(brk_open));
  task automatic end_sim;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Scenarios need about 600 cycles; the ceiling only catches a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      end_sim;
    end
  end
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Sampling on falling edges keeps clear of the design's own updates
  task automatic see(string nm, int k, int n, bit want);
    bit unk = 1'b0;
    c = 0;
    repeat (n) begin
      @(negedge clk);
      if (o[k] === 1'b1) c++;
      if ($isunknown(o[k])) unk = 1'b1;
    end
    @(posedge clk);
    // An unknown output must never pass as quiet
    chk(nm, unk ? 16'hFFFF : 16'(c > 0), 16'(want));
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_ovc;
    {lim, ctl} <= {1'b1, lvl - 16'h0001};
    see("ovc_disabled", 0, 12, 0);
    {ovc_en, ctl} <= {1'b1, lvl};
    see("ovc_at_level", 0, 12, 0);
    {lim, ctl} <= {1'b0, lvl - 16'h0001};
    see("ovc_no_limiter", 0, 12, 0);
    lim <= 1'b1;
    see("ovc_partial", 0, 5, 0);
    ctl <= lvl;
    see("ovc_gap", 0, 2, 0);
    ctl <= lvl - 16'h0001;
    see("ovc_restart", 0, 6, 0);
    see("ovc_trip", 0, 6, 1);
  endtask
  task automatic t_open;
    {open_en, ctl, cur} <= {1'b1, lvl + 16'h0001, OPEN_CUR_LO_DEF};
    see("open_cur_at_low", 1, 12, 0);
    cur <= OPEN_CUR_LO_DEF - 16'h0001;
    see("open_early", 1, 6, 0);
    see("open_trip", 1, 6, 1);
    open_en <= 1'b0;
    repeat (2) @(posedge clk);
    see("open_disabled", 1, 4, 0);
    see("exc_stop_held", 2, 4, 1);
    {ctl, cur} <= {lvl, 16'h0032};
  endtask
  task automatic t_temp;
    {ovc_en, temp} <= {1'b0, TEMP_ALARM_DEF};
    see("temp_at_level", 3, 6, 0);
    temp <= TEMP_ALARM_DEF + 16'h0001;
    see("temp_event", 4, 6, 1);
    chk("temp_event_count", 16'(c), 16'h0001);
    see("temp_alarm", 3, 2, 1);
  endtask
  task automatic t_brk(bit en, bit mc, bit stk);
    {trip_en, mco, stuck, off_req} <= {en, mc, stk, 1'b1};
    see("rundown", 5, 3, en & mc);
    see("open_cmd_wait", 6, 1, 0);
    see("open_cmd", 6, 12, en & mc);
    see("fail_event", 7, 24, en & mc & stk);
    chk("fail_count", 16'(c), 16'(en & mc & stk));
    off_req <= 1'b0;
    repeat (2) @(posedge clk);
    see("cmd_release", 6, 4, 0);
  endtask
  // One step per ten cycles at this rate and divider
  task automatic t_ramp;
    ctl <= 16'h01F4;
    repeat (3) @(negedge clk);
    chk("forced_track", forced, 16'h01F4);
    @(posedge clk);
    {olr, up} <= 2'b11;
    repeat (200) @(negedge clk);
    chk("ramp_up", 16'(forced >= 16'h0207 && forced <= 16'h0209),
      16'h0001);
    @(posedge clk);
    {up, dn} <= 2'b01;
    repeat (100) @(negedge clk);
    chk("ramp_down", 16'(forced >= 16'h01FE && forced <= 16'h0200),
      16'h0001);
  endtask
  initial begin
    repeat (9) @(posedge clk);
    @(negedge clk);
    chk("reset_outputs", {8'h00, o}, 16'h0000);
    chk("reset_forced", forced, 16'h0000);
    @(posedge clk);
    rst <= 1'b0;
    t_ovc;
    t_open;
    t_temp;
    t_brk(1'b0, 1'b1, 1'b0);
    t_brk(1'b1, 1'b0, 1'b0);
    t_brk(1'b1, 1'b1, 1'b0);
    t_brk(1'b1, 1'b1, 1'b1);
    t_ramp;
    end_sim;
  end
endmodule // test_efs_supervision
